//--- rtl/tap_top.sv
// Overview of operation
// - Instruction register is ten bits; opcodes shift in ten bits long.
// - Bypass puts one flop between data in and out; one clock delay.
// - Sample/preload captures pin states and loads an initial output pattern.
// - Extest drives the cell pattern onto pins and captures pin inputs.
// - Identification instruction shifts out the 32-bit identification word.
// - User code instruction shifts out a 32-bit user code value.
// - User signature instruction shifts out a 16-bit user signature.
// - Identification word: version, part number, maker code, constant bit, MSB first.
// - Identification word LSB always reads one.
// - Boundary chain length set by density, 96 to 624 cells.
// - Programming instructions erase, program and verify nonvolatile configuration.
// - With the test port unused, its pins serve as plain user pins.
`timescale 1ns/100ps
`default_nettype none
module tap_top #(
   parameter int BSR_LEN = tap_pkg::TAP_BSR_LEN_DEF,
   parameter logic [3:0] ID_VER = tap_pkg::TAP_ID_VER_DEF,
   parameter logic [15:0] ID_PART = tap_pkg::TAP_ID_PART_DEF,
   parameter logic [10:0] ID_MFR = tap_pkg::TAP_ID_MFR_DEF,
   parameter logic [31:0] USER_CODE = tap_pkg::TAP_USER_CODE_DEF,
   parameter logic [15:0] USER_SIG = tap_pkg::TAP_USIG_DEF
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo_o,
   output logic tdo_oe_n,
   input wire logic tap_enable,
   input wire logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] pin_i,
   output logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] pin_o,
   output logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] pin_oe_n,
   input wire logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] core_out,
   input wire logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] core_oe,
   output logic [BSR_LEN/tap_pkg::TAP_CELLS_PER_PIN-1:0] core_in,
   output logic isp_req,
   output var tap_pkg::tap_isp_cmd_s isp_cmd,
   input wire logic [tap_pkg::TAP_DR_W-1:0] isp_rdata,
   input wire logic isp_rdata_valid
);
   import tap_pkg::*;

   localparam int NPIN = BSR_LEN / TAP_CELLS_PER_PIN;
   localparam int SNAP_W = 3 * NPIN;

   // ---------------- Test clock domain ----------------
   logic rsync1_ff, rsync2_ff, en1_ff, en2_ff;
   logic trst, hold;
   tap_state_e state_ff, nxt_state;
   logic [TAP_IR_W-1:0] ir_sr_ff, ir_ff;
   tap_dr_e dr_sel;
   logic byp_ff;
   logic [TAP_DR_W-1:0] gen_sr_ff, nxt_gen_sr, identification_register_w;
   logic [SNAP_W-1:0] snap1_ff, snap2_ff;
   logic [BSR_LEN-1:0] bsr_cap, bsr_upd;
   logic bsr_so, dr_out;
   logic xtog_ff, isp_tog_t_ff;
   tap_isp_cmd_s isp_cmd_t_ff;
   logic rs1_ff, rs2_ff, rs3_ff;
   logic [TAP_DR_W-1:0] isp_rd_t_ff;
   logic tdo_ff, tdo_oe_n_ff;
   // Read-back toggle and word live on the system clock but are read here
   logic rtog_c_ff;
   logic [TAP_DR_W-1:0] rd_c_ff;

   // Chip reset and port enable reach the test clock through two flops
   always_ff @(posedge tck) begin
      rsync1_ff <= rstn;
      rsync2_ff <= rsync1_ff;
   end
   assign trst = !rsync2_ff;

   always_ff @(posedge tck) begin
      if (trst) begin
         en1_ff <= 1'b0;
         en2_ff <= 1'b0;
      end else begin
         en1_ff <= tap_enable;
         en2_ff <= en1_ff;
      end
   end
   // Disabled port parks the controller so the pins are free for user logic
   assign hold = trst || !en2_ff;

   always_ff @(posedge tck) begin
      if (hold) begin
         state_ff <= TAP_TLR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      case (state_ff)
         TAP_TLR: nxt_state = tms ? TAP_TLR : TAP_RTI;
         TAP_RTI: nxt_state = tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_DR: nxt_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nxt_state = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: nxt_state = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: nxt_state = tms ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: nxt_state = tms ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: nxt_state = tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: nxt_state = tms ? TAP_SEL_DR : TAP_RTI;
         TAP_SEL_IR: nxt_state = tms ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: nxt_state = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: nxt_state = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: nxt_state = tms ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: nxt_state = tms ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: nxt_state = tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: nxt_state = tms ? TAP_SEL_DR : TAP_RTI;
         default: nxt_state = TAP_TLR;
      endcase
   end

   // Instruction shift stage and held instruction
   always_ff @(posedge tck) begin
      if (hold) begin
         ir_sr_ff <= TAP_IR_RST;
      end else if (state_ff == TAP_CAP_IR) begin
         ir_sr_ff <= TAP_IR_CAPTURE;
      end else if (state_ff == TAP_SH_IR) begin
         ir_sr_ff <= {tdi, ir_sr_ff[TAP_IR_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (hold || state_ff == TAP_TLR) begin
         ir_ff <= TAP_OP_IDENTIFICATION_REGISTER;
      end else if (state_ff == TAP_UPD_IR) begin
         ir_ff <= ir_sr_ff;
      end
   end

   // Unknown opcodes fall back to bypass so the chain length stays defined
   assign dr_sel = tap_dr_decode(ir_ff);

   always_ff @(posedge tck) begin
      if (hold || (state_ff == TAP_CAP_DR && dr_sel == TAP_DR_BYP)) begin
         byp_ff <= 1'b0;
      end else if (state_ff == TAP_SH_DR && dr_sel == TAP_DR_BYP) begin
         byp_ff <= tdi;
      end
   end

   assign identification_register_w = {ID_VER, ID_PART, ID_MFR, 1'b1};

   // One shared shift stage serves the identification, user and programming paths
   always_comb begin
      nxt_gen_sr = gen_sr_ff;
      if (state_ff == TAP_CAP_DR) begin
         case (dr_sel)
            TAP_DR_ID: nxt_gen_sr = identification_register_w;
            TAP_DR_UCODE: nxt_gen_sr = USER_CODE;
            TAP_DR_USIG: nxt_gen_sr = {{(TAP_DR_W-TAP_USIG_W){1'b0}}, USER_SIG};
            TAP_DR_ISP: nxt_gen_sr = isp_rd_t_ff;
            default: nxt_gen_sr = gen_sr_ff;
         endcase
      end else if (state_ff == TAP_SH_DR) begin
         nxt_gen_sr = gen_sr_ff >> 1;
         if (dr_sel == TAP_DR_USIG) begin
            nxt_gen_sr[TAP_USIG_W-1] = tdi;
         end else begin
            nxt_gen_sr[TAP_DR_W-1] = tdi;
         end
      end
   end

   always_ff @(posedge tck) begin
      if (hold) begin
         gen_sr_ff <= TAP_DR_RST;
      end else begin
         gen_sr_ff <= nxt_gen_sr;
      end
   end

   // Pin states and core drive levels sampled into the test clock domain
   always_ff @(posedge tck) begin
      snap1_ff <= {core_oe, core_out, pin_i};
      snap2_ff <= snap1_ff;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_cap
         assign bsr_cap[TAP_CELLS_PER_PIN*gi+TAP_CELL_IN] = snap2_ff[gi];
         assign bsr_cap[TAP_CELLS_PER_PIN*gi+TAP_CELL_OUT] = snap2_ff[NPIN+gi];
         assign bsr_cap[TAP_CELLS_PER_PIN*gi+TAP_CELL_OE] = snap2_ff[2*NPIN+gi];
      end
   endgenerate

   tap_bsr_chain #(
      .LEN(BSR_LEN)
   ) u_bsr (
      .tck(tck),
      .rst(hold),
      .capture_en(state_ff == TAP_CAP_DR && dr_sel == TAP_DR_BSR),
      .shift_en(state_ff == TAP_SH_DR && dr_sel == TAP_DR_BSR),
      .update_en(state_ff == TAP_UPD_DR && dr_sel == TAP_DR_BSR),
      .tdi(tdi),
      .cap(bsr_cap),
      .so(bsr_so),
      .upd(bsr_upd)
   );

   // Toggle announces a new pin pattern or mode; data is stable long before it lands
   always_ff @(posedge tck) begin
      if (trst) begin
         xtog_ff <= 1'b0;
      end else if (state_ff == TAP_UPD_DR || state_ff == TAP_UPD_IR ||
                   (state_ff == TAP_TLR && ir_ff != TAP_OP_IDENTIFICATION_REGISTER)) begin
         xtog_ff <= !xtog_ff;
      end
   end

   // Programming commands leave on update of the programming data path
   always_ff @(posedge tck) begin
      if (trst) begin
         isp_tog_t_ff <= 1'b0;
         isp_cmd_t_ff <= '0;
      end else if (!hold && state_ff == TAP_UPD_DR && dr_sel == TAP_DR_ISP) begin
         isp_tog_t_ff <= !isp_tog_t_ff;
         isp_cmd_t_ff <= '{op: tap_isp_decode(ir_ff), word: gen_sr_ff};
      end
   end

   // Verify read-back arrives by toggle from the system clock
   always_ff @(posedge tck) begin
      if (trst) begin
         rs1_ff <= 1'b0;
         rs2_ff <= 1'b0;
         rs3_ff <= 1'b0;
         isp_rd_t_ff <= TAP_DR_RST;
      end else begin
         rs1_ff <= rtog_c_ff;
         rs2_ff <= rs1_ff;
         rs3_ff <= rs2_ff;
         if (rs2_ff != rs3_ff) begin
            isp_rd_t_ff <= rd_c_ff;
         end
      end
   end

   always_comb begin
      case (dr_sel)
         TAP_DR_BYP: dr_out = byp_ff;
         TAP_DR_BSR: dr_out = bsr_so;
         default: dr_out = gen_sr_ff[0];
      endcase
   end

   // Output changes on the falling edge so the far end samples a settled bit
   always_ff @(negedge tck) begin
      if (hold) begin
         tdo_ff <= 1'b0;
         tdo_oe_n_ff <= 1'b1;
      end else begin
         tdo_ff <= (state_ff == TAP_SH_IR) ? ir_sr_ff[0] : dr_out;
         tdo_oe_n_ff <= !(state_ff == TAP_SH_IR || state_ff == TAP_SH_DR);
      end
   end
   assign tdo_o = tdo_ff;
   assign tdo_oe_n = tdo_oe_n_ff;

   // ---------------- System clock domain ----------------
   logic xs1_ff, xs2_ff, xs3_ff, is1_ff, is2_ff, is3_ff;
   logic extest_c_ff, isp_req_ff;
   logic [BSR_LEN-1:0] drive_c_ff;
   logic [NPIN-1:0] ext_dat, ext_en, pin_o_ff, pin_oe_n_ff, pc1_ff, pc2_ff;
   tap_isp_cmd_s isp_cmd_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         xs1_ff <= 1'b0;
         xs2_ff <= 1'b0;
         xs3_ff <= 1'b0;
         extest_c_ff <= 1'b0;
         drive_c_ff <= '0;
      end else begin
         xs1_ff <= xtog_ff;
         xs2_ff <= xs1_ff;
         xs3_ff <= xs2_ff;
         if (xs2_ff != xs3_ff) begin
            extest_c_ff <= (ir_ff == TAP_OP_EXTEST);
            drive_c_ff <= bsr_upd;
         end
      end
   end

   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_drv
         assign ext_dat[gi] = drive_c_ff[TAP_CELLS_PER_PIN*gi+TAP_CELL_OUT];
         assign ext_en[gi] = drive_c_ff[TAP_CELLS_PER_PIN*gi+TAP_CELL_OE];
      end
   endgenerate

   // Sample/preload never disturbs the pins; only extest takes them over
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pin_o_ff <= '0;
         pin_oe_n_ff <= '1;
      end else if (extest_c_ff) begin
         pin_o_ff <= ext_dat;
         pin_oe_n_ff <= ~ext_en;
      end else begin
         pin_o_ff <= core_out;
         pin_oe_n_ff <= ~core_oe;
      end
   end
   assign pin_o = pin_o_ff;
   assign pin_oe_n = pin_oe_n_ff;

   always_ff @(posedge clk) begin
      pc1_ff <= pin_i;
      pc2_ff <= pc1_ff;
   end
   assign core_in = pc2_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         is1_ff <= 1'b0;
         is2_ff <= 1'b0;
         is3_ff <= 1'b0;
         isp_req_ff <= 1'b0;
         isp_cmd_ff <= '0;
      end else begin
         is1_ff <= isp_tog_t_ff;
         is2_ff <= is1_ff;
         is3_ff <= is2_ff;
         isp_req_ff <= (is2_ff != is3_ff);
         if (is2_ff != is3_ff) begin
            isp_cmd_ff <= isp_cmd_t_ff;
         end
      end
   end
   assign isp_req = isp_req_ff;
   assign isp_cmd = isp_cmd_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rtog_c_ff <= 1'b0;
         rd_c_ff <= TAP_DR_RST;
      end else if (isp_rdata_valid) begin
         rtog_c_ff <= !rtog_c_ff;
         rd_c_ff <= isp_rdata;
      end
   end

   // ---------------- Checks ----------------
   a_ir_capture: assert property (@(posedge tck) disable iff (hold)
      state_ff == TAP_CAP_IR |=> ir_sr_ff == TAP_IR_CAPTURE)
      else $error("instruction capture pattern wrong");

   a_bypass_delay: assert property (@(posedge tck) disable iff (hold)
      (state_ff == TAP_SH_DR && dr_sel == TAP_DR_BYP) |=> byp_ff == $past(tdi))
      else $error("bypass flop did not take data in");

   a_identification_register_word: assert property (@(posedge tck) disable iff (hold)
      (state_ff == TAP_CAP_DR && dr_sel == TAP_DR_ID) |=>
         gen_sr_ff[0] && gen_sr_ff[TAP_DR_W-1:TAP_ID_VER_LSB] == ID_VER &&
         gen_sr_ff[TAP_ID_VER_LSB-1:TAP_ID_PART_LSB] == ID_PART &&
         gen_sr_ff[TAP_ID_PART_LSB-1:TAP_ID_MFR_LSB] == ID_MFR)
      else $error("identification word loaded wrong");

   a_ucode_load: assert property (@(posedge tck) disable iff (hold)
      (state_ff == TAP_CAP_DR && dr_sel == TAP_DR_UCODE) |=> gen_sr_ff == USER_CODE)
      else $error("user code not loaded");

   a_usig_load: assert property (@(posedge tck) disable iff (hold)
      (state_ff == TAP_CAP_DR && dr_sel == TAP_DR_USIG) ##1 (state_ff == TAP_SH_DR)
         |-> gen_sr_ff[TAP_USIG_W-1:0] == USER_SIG)
      else $error("user signature not loaded");

   a_tms_reset: assert property (@(posedge tck) disable iff (hold)
      tms [*5] |=> state_ff == TAP_TLR)
      else $error("five ones on mode select did not reset controller");

   a_port_off: assert property (@(posedge tck) disable iff (trst)
      !en2_ff |=> state_ff == TAP_TLR && ir_ff == TAP_OP_IDENTIFICATION_REGISTER)
      else $error("disabled port not parked");

   a_extest_drive: assert property (@(posedge clk) disable iff (!rstn)
      extest_c_ff |=> pin_o_ff == $past(ext_dat) && pin_oe_n_ff == ~$past(ext_en))
      else $error("extest pattern not on pins");

   a_isp_accept: assert property (@(posedge clk) disable iff (!rstn)
      (is2_ff != is3_ff) |=> isp_req_ff && isp_cmd_ff == $past(isp_cmd_t_ff) ##1 !isp_req_ff)
      else $error("programming command not delivered as one pulse");

endmodule : tap_top
`default_nettype wire

//--- rtl/tap_pkg.sv
package tap_pkg;

   // Register widths and chain geometry
   localparam int TAP_IR_W = 10;
   localparam int TAP_DR_W = 32;
   localparam int TAP_USIG_W = 16;
   localparam int TAP_BSR_LEN_DEF = 96;
   localparam int TAP_CELLS_PER_PIN = 3;
   localparam int TAP_CELL_IN = 0;
   localparam int TAP_CELL_OUT = 1;
   localparam int TAP_CELL_OE = 2;

   // Identification word field positions
   localparam int TAP_ID_VER_LSB = 28;
   localparam int TAP_ID_PART_LSB = 12;
   localparam int TAP_ID_MFR_LSB = 1;

   // Values after reset and capture patterns
   localparam logic [TAP_IR_W-1:0] TAP_IR_CAPTURE = 10'h001;
   localparam logic [TAP_IR_W-1:0] TAP_IR_RST = 10'h000;
   localparam logic [TAP_DR_W-1:0] TAP_DR_RST = 32'h0000_0000;

   // Instruction opcodes
   localparam logic [TAP_IR_W-1:0] TAP_OP_EXTEST = 10'h000;
   localparam logic [TAP_IR_W-1:0] TAP_OP_SAMPLE = 10'h005;
   localparam logic [TAP_IR_W-1:0] TAP_OP_IDENTIFICATION_REGISTER = 10'h006;
   localparam logic [TAP_IR_W-1:0] TAP_OP_USER_CODE_REGISTER = 10'h007;
   localparam logic [TAP_IR_W-1:0] TAP_OP_USIG = 10'h008;
   localparam logic [TAP_IR_W-1:0] TAP_OP_ISP_ENABLE = 10'h010;
   localparam logic [TAP_IR_W-1:0] TAP_OP_ISP_ERASE = 10'h011;
   localparam logic [TAP_IR_W-1:0] TAP_OP_ISP_PROGRAM = 10'h012;
   localparam logic [TAP_IR_W-1:0] TAP_OP_ISP_VERIFY = 10'h013;
   localparam logic [TAP_IR_W-1:0] TAP_OP_ISP_EXIT = 10'h014;
   localparam logic [TAP_IR_W-1:0] TAP_OP_BYPASS = 10'h3FF;

   // Identity values: arbitrary, not tied to any real maker or part
   localparam logic [3:0] TAP_ID_VER_DEF = 4'h2;
   localparam logic [15:0] TAP_ID_PART_DEF = 16'hA5C3;
   localparam logic [10:0] TAP_ID_MFR_DEF = 11'h2B4;
   localparam logic [31:0] TAP_USER_CODE_DEF = 32'hFFFF_FFFF;
   localparam logic [15:0] TAP_USIG_DEF = 16'hFFFF;

   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } tap_state_e;

   typedef enum logic [2:0] {
      TAP_DR_BYP, TAP_DR_BSR, TAP_DR_ID, TAP_DR_UCODE, TAP_DR_USIG, TAP_DR_ISP
   } tap_dr_e;

   typedef enum logic [2:0] {
      TAP_ISP_NONE, TAP_ISP_ENABLE, TAP_ISP_ERASE, TAP_ISP_PROGRAM, TAP_ISP_VERIFY,
      TAP_ISP_EXIT
   } tap_isp_op_e;

   typedef struct packed {
      tap_isp_op_e op;
      logic [TAP_DR_W-1:0] word;
   } tap_isp_cmd_s;

   function automatic tap_dr_e tap_dr_decode(input logic [TAP_IR_W-1:0] op);
      case (op)
         TAP_OP_EXTEST, TAP_OP_SAMPLE: tap_dr_decode = TAP_DR_BSR;
         TAP_OP_IDENTIFICATION_REGISTER: tap_dr_decode = TAP_DR_ID;
         TAP_OP_USER_CODE_REGISTER: tap_dr_decode = TAP_DR_UCODE;
         TAP_OP_USIG: tap_dr_decode = TAP_DR_USIG;
         TAP_OP_ISP_ENABLE, TAP_OP_ISP_ERASE, TAP_OP_ISP_PROGRAM, TAP_OP_ISP_VERIFY,
         TAP_OP_ISP_EXIT: tap_dr_decode = TAP_DR_ISP;
         default: tap_dr_decode = TAP_DR_BYP;
      endcase
   endfunction : tap_dr_decode

   function automatic tap_isp_op_e tap_isp_decode(input logic [TAP_IR_W-1:0] op);
      case (op)
         TAP_OP_ISP_ENABLE: tap_isp_decode = TAP_ISP_ENABLE;
         TAP_OP_ISP_ERASE: tap_isp_decode = TAP_ISP_ERASE;
         TAP_OP_ISP_PROGRAM: tap_isp_decode = TAP_ISP_PROGRAM;
         TAP_OP_ISP_VERIFY: tap_isp_decode = TAP_ISP_VERIFY;
         TAP_OP_ISP_EXIT: tap_isp_decode = TAP_ISP_EXIT;
         default: tap_isp_decode = TAP_ISP_NONE;
      endcase
   endfunction : tap_isp_decode

endpackage : tap_pkg

//--- rtl/tap_bsr_chain.sv
`timescale 1ns/100ps
`default_nettype none
module tap_bsr_chain #(
   parameter int LEN = tap_pkg::TAP_BSR_LEN_DEF
) (
   input wire logic tck,
   input wire logic rst,
   input wire logic capture_en,
   input wire logic shift_en,
   input wire logic update_en,
   input wire logic tdi,
   input wire logic [LEN-1:0] cap,
   output logic so,
   output logic [LEN-1:0] upd
);
   import tap_pkg::*;

   logic [LEN-1:0] sr_ff;
   logic [LEN-1:0] upd_ff;

   // Capture and shift stage; bit 0 leaves first
   always_ff @(posedge tck) begin
      if (rst) begin
         sr_ff <= '0;
      end else if (capture_en) begin
         sr_ff <= cap;
      end else if (shift_en) begin
         sr_ff <= {tdi, sr_ff[LEN-1:1]};
      end
   end

   // Update stage holds the pattern steady while the next one shifts in
   always_ff @(posedge tck) begin
      if (rst) begin
         upd_ff <= '0;
      end else if (update_en) begin
         upd_ff <= sr_ff;
      end
   end

   assign so = sr_ff[0];
   assign upd = upd_ff;

   a_bsr_capture: assert property (@(posedge tck) disable iff (rst)
      capture_en |=> sr_ff == $past(cap))
      else $error("boundary cells did not capture pin states");

   a_bsr_preload: assert property (@(posedge tck) disable iff (rst)
      (update_en && !capture_en) |=> (upd_ff == $past(sr_ff)) ##1 $stable(upd_ff))
      else $error("preload pattern not moved to update stage");

endmodule : tap_bsr_chain
`default_nettype wire

//--- dv/tap_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tap_host_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe_n,
   output logic rsp_valid,
   output logic [127:0] rsp_data
);
   logic q;
   logic oe_n;
   logic drv;
   logic any;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      rsp_valid = 1'b0;
      rsp_data = '0;
   end
   // Tck rests low between frames; tdo is taken just before the rising edge
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #15;
      // A released line shows no trustworthy level
      q = tdo_oe_n ? ~tdo_o : tdo_o;
      oe_n = tdo_oe_n;
      tck = 1'b1;
      #15;
      tck = 1'b0;
   endtask : step
   task automatic park(input int n);
      repeat (n) step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask : park
   task automatic scan(input logic ir, input int n, input logic [127:0] din, input logic note);
      logic [127:0] dout;
      dout = '0;
      drv = 1'b1;
      any = 1'b0;
      step(1'b1, ~tdi);
      if (ir) step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      // Tdi toggles outside shifting so a stale level never passes for data
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         dout[i] = q;
         drv = drv & ~oe_n;
         any = any | ~oe_n;
      end
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      if (note) begin
         dout[127] = drv;
         rsp_data = dout;
         rsp_valid = 1'b1;
         #1;
         rsp_valid = 1'b0;
      end
   endtask : scan
endmodule : tap_host_model
`default_nettype wire

//--- dv/test_tap_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_tap_top;
   import tap_pkg::*;
   localparam int NPIN = TAP_BSR_LEN_DEF / TAP_CELLS_PER_PIN;
   localparam logic [31:0] UCODE = 32'h5A3C_0F96;
   localparam logic [15:0] USIG = 16'h3C96;
   localparam logic [31:0] ID_WORD = {TAP_ID_VER_DEF, TAP_ID_PART_DEF, TAP_ID_MFR_DEF, 1'b1};
   logic clk, rstn, tck, tms, tdi, tdo_o, tdo_oe_n, tap_enable, isp_req, isp_rdata_valid;
   logic rsp_valid;
   logic [127:0] rsp_data, pat, bsr;
   logic [NPIN-1:0] pin_i, pin_o, pin_oe_n, core_out, core_oe, core_in;
   logic [31:0] isp_rdata, r;
   logic [15:0] rnd;
   tap_isp_cmd_s isp_cmd;
   logic [127:0] exp_q[$];
   tap_isp_cmd_s isp_q[$];
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR at %0t: got %h, expected %h", $time, (a), (b)); end end

   tap_top #(.USER_CODE(UCODE), .USER_SIG(USIG)) i_tap_top (.clk(clk), .rstn(rstn),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
      .tap_enable(tap_enable), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .isp_req(isp_req),
      .isp_cmd(isp_cmd), .isp_rdata(isp_rdata), .isp_rdata_valid(isp_rdata_valid));
   tap_host_model i_tap_host_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
      .tdo_oe_n(tdo_oe_n), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic roll(output logic [31:0] v);
      rnd = lfsr(rnd);
      v[15:0] = rnd;
      rnd = lfsr(rnd);
      v[31:16] = rnd;
   endtask : roll
   // Every shift also expects tdo driven on all its bits, noted in bit 127
   task automatic ir(input logic [9:0] op);
      exp_q.push_back({1'b1, 117'h0, TAP_IR_CAPTURE});
      i_tap_host_model.scan(1'b1, TAP_IR_W, {118'h0, op}, 1'b1);
   endtask : ir
   task automatic dr(input int n, input logic [127:0] din, input logic [127:0] exp);
      exp_q.push_back({1'b1, exp[126:0]});
      i_tap_host_model.scan(1'b0, n, din, 1'b1);
   endtask : dr
   always @(posedge rsp_valid) begin
      `CHK(rsp_data, exp_q.pop_front())
   end
   always @(posedge clk) begin
      if (isp_req === 1'b1) begin
         `CHK(isp_cmd, isp_q.pop_front())
      end
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      rstn = 1'b0;
      tap_enable = 1'b1;
      pin_i = '0;
      core_out = '0;
      core_oe = '0;
      isp_rdata = '0;
      isp_rdata_valid = 1'b0;
      rnd = 16'hCEF6;
      // Reset stays low until the test clock has seen it as well
      i_tap_host_model.park(6);
      @(posedge clk);
      rstn <= 1'b1;
      i_tap_host_model.park(6);
      dr(32, '1, {96'h0, ID_WORD});
      ir(TAP_OP_USER_CODE_REGISTER);
      dr(32, '0, {96'h0, UCODE});
      ir(TAP_OP_USIG);
      dr(16, '1, {112'h0, USIG});
      for (int k = 0; k < 2; k++) begin
         roll(r);
         ir(k == 0 ? TAP_OP_BYPASS : {1'b1, r[8:0]});
         dr(8, {120'h0, r[7:0]}, {120'h0, r[6:0], 1'b0});
      end
      // Five ones from idle must reach reset state and restore the ID instruction
      i_tap_host_model.park(5);
      dr(32, '0, {96'h0, ID_WORD});
      roll(r);
      @(posedge clk);
      pin_i <= r;
      roll(r);
      core_out <= r;
      roll(r);
      core_oe <= r;
      pat = '0;
      roll(pat[31:0]);
      roll(pat[63:32]);
      roll(pat[95:64]);
      repeat (4) @(posedge clk);
      bsr = '0;
      for (int i = 0; i < NPIN; i++) begin
         bsr[3 * i +: 3] = {core_oe[i], core_out[i], pin_i[i]};
      end
      ir(TAP_OP_SAMPLE);
      dr(TAP_BSR_LEN_DEF, pat, bsr);
      repeat (8) @(posedge clk);
      `CHK(pin_o, core_out)
      `CHK(pin_oe_n, ~core_oe)
      `CHK(core_in, pin_i)
      ir(TAP_OP_EXTEST);
      repeat (8) @(posedge clk);
      for (int i = 0; i < NPIN; i++) begin
         `CHK(pin_o[i], pat[3 * i + 1])
         `CHK(pin_oe_n[i], ~pat[3 * i + 2])
      end
      ir(TAP_OP_BYPASS);
      repeat (8) @(posedge clk);
      `CHK(pin_o, core_out)
      for (int k = 0; k < 5; k++) begin
         roll(r);
         @(posedge clk);
         isp_rdata <= r;
         isp_rdata_valid <= 1'b1;
         @(posedge clk);
         isp_rdata_valid <= 1'b0;
         roll(pat[31:0]);
         ir(TAP_OP_ISP_ENABLE + 10'(k));
         isp_q.push_back('{tap_isp_op_e'(k + 1), pat[31:0]});
         dr(32, {96'h0, pat[31:0]}, {96'h0, r});
      end
      @(posedge clk);
      tap_enable <= 1'b0;
      repeat (4) @(posedge clk);
      i_tap_host_model.scan(1'b0, 8, '1, 1'b0);
      `CHK(i_tap_host_model.any, 1'b0)
      @(posedge clk);
      tap_enable <= 1'b1;
      i_tap_host_model.park(6);
      dr(32, '0, {96'h0, ID_WORD});
      repeat (10) @(posedge clk);
      `CHK(exp_q.size() + isp_q.size(), 0)
      complete_run();
   end
endmodule : test_tap_top
`default_nettype wire
